/* rtl/uamar_pkg.sv */
package uamar_pkg;

   // register byte offsets (printed offsets are not all multiples of four: index * 4)
   localparam logic [11:0] SERIAL_CONTROL_IDX     = 12'h098;
   localparam logic [11:0] SERIAL_BUFFER_IDX      = 12'h099;
   localparam logic [11:0] NODE_ADDRESS_VALUE_IDX = 12'h0A9;
   localparam logic [11:0] NODE_ADDRESS_MASK_IDX  = 12'h0B9;
   localparam logic [11:0] AUX_CONTROL_IDX        = 12'h0C0;
   localparam logic [13:0] SERIAL_CONTROL_ADDR     = {SERIAL_CONTROL_IDX, 2'b00};
   localparam logic [13:0] SERIAL_BUFFER_ADDR      = {SERIAL_BUFFER_IDX, 2'b00};
   localparam logic [13:0] NODE_ADDRESS_VALUE_ADDR = {NODE_ADDRESS_VALUE_IDX, 2'b00};
   localparam logic [13:0] NODE_ADDRESS_MASK_ADDR  = {NODE_ADDRESS_MASK_IDX, 2'b00};
   localparam logic [13:0] AUX_CONTROL_ADDR        = {AUX_CONTROL_IDX, 2'b00};

   // serial_control field positions
   localparam int CTL_BIT7 = 7;
   localparam int CTL_MODE1 = 6;
   localparam int CTL_MPEN = 5;
   localparam int CTL_RXEN = 4;
   localparam int CTL_TX9 = 3;
   localparam int CTL_RX9 = 2;
   localparam int CTL_TXDONE = 1;
   localparam int CTL_RXDONE = 0;
   // aux_control field positions
   localparam int AUX_FCSEL = 0;
   localparam int AUX_SIE = 1;
   localparam int AUX_GIE = 2;

   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] ADDR_RESET    = 8'h00;
   localparam logic [2:0] AUX_RESET     = 3'h0;

   // 16 sample ticks per bit; mid-bit sample at tick 8
   localparam logic [3:0] OVS_LAST = 4'hF;
   localparam logic [3:0] OVS_MID  = 4'h7;
   localparam logic [3:0] BITS_8   = 4'h8;
   localparam logic [3:0] BITS_9   = 4'h9;

   typedef enum logic [1:0] {
      MODE_SHIFT = 2'b00,
      MODE_8VAR  = 2'b01,
      MODE_9FIX  = 2'b10,
      MODE_9VAR  = 2'b11
   } uamar_mode_type;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b11,
      RX_STOP  = 2'b10
   } uamar_rx_state_type;

   typedef struct packed {
      logic [7:0] data;
      logic       marker;
   } uamar_frame_type;

endpackage : uamar_pkg

/* rtl/uamar_top.sv */
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - multiprocessor enable in nine-bit modes marks ninth-bit-set frames as addresses
// - with multiprocessor enable, ninth-bit-clear frames are dropped without rx done flag or load
// - matching address frame sets rx ninth bit and rx done flag
// - eight-bit mode with enable: match plus valid stop bit needed for rx done
// - in shift mode the multiprocessor enable has no effect
// - individual address compared only where mask bit is one
// - broadcast address is value OR mask, zero bits are don't care
// - match when either masked individual or broadcast address agrees
// - address value and mask reset to zero so every address matches
// - rx done and tx done are ORed into one serial request
// - hardware never clears done flags; software writes zero
// - request reaches core only with serial and global enables set
// - bit 7 is framing error when check selected, else mode bit 0
// - bit 4 enables receiver; bit 6 mode bit 1; bit 5 multiproc enable
// - nine-bit modes transmit bit 3 as ninth bit
// - bit 2 captures stop bit in eight-bit mode, ninth bit in nine-bit modes
// - tx done set after last data bit is sent
// - rx done set at mid stop bit of accepted frame
// - nine-bit frame is start, eight data LSB first, ninth, stop
// - framing error stays set until software or reset clears it
// - reception starts on high-to-low transition of receive line
module uamar_top (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [15:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // baud: one pulse per sample tick, 16 per bit
   input  wire logic        sample_tick_i,
   // serial line
   input  wire logic        rxd_i,
   output logic             txd_o,
   // interrupt request toward core
   output logic             serial_irq_o
);

   logic [7:0] ctl_reg;
   logic       mode0_reg;
   logic       fe_reg;
   logic [7:0] buf_reg;
   logic [7:0] addr_reg;
   logic [7:0] mask_reg;
   logic [2:0] aux_reg;
   logic [31:0] prdata_reg;
   logic       pready_reg;
   logic       pslverr_reg;
   logic       irq_reg;

   // apb decode
   wire        acc      = psel_i & penable_i;
   wire        wr       = acc & pwrite_i & pstrb_i[0];
   wire        in_range = paddr_i[15:14] == 2'b00;
   wire [13:0] a        = paddr_i[13:0];
   wire        hit_ctl  = in_range & (a == uamar_pkg::SERIAL_CONTROL_ADDR);
   wire        hit_buf  = in_range & (a == uamar_pkg::SERIAL_BUFFER_ADDR);
   wire        hit_addr = in_range & (a == uamar_pkg::NODE_ADDRESS_VALUE_ADDR);
   wire        hit_mask = in_range & (a == uamar_pkg::NODE_ADDRESS_MASK_ADDR);
   wire        hit_aux  = in_range & (a == uamar_pkg::AUX_CONTROL_ADDR);
   wire        hit_any  = hit_ctl | hit_buf | hit_addr | hit_mask | hit_aux;
   // writes land on the edge that also samples pready high, as the master sees it
   wire        wr_ctl   = wr & hit_ctl & pready_reg;
   wire        wr_buf   = wr & hit_buf & pready_reg;

   wire        fcsel = aux_reg[uamar_pkg::AUX_FCSEL];
   wire [1:0]  mode  = {mode0_reg, ctl_reg[uamar_pkg::CTL_MODE1]};
   wire        nine  = mode[1];
   wire        mpen  = ctl_reg[uamar_pkg::CTL_MPEN] & (mode != uamar_pkg::MODE_SHIFT);
   wire        bit7  = fcsel ? fe_reg : mode0_reg;
   wire [7:0]  ctl_rd = {bit7, ctl_reg[6:0]};
   wire [31:0] rd_mux = hit_ctl  ? {24'h000000, ctl_rd}  :
                        hit_buf  ? {24'h000000, buf_reg} :
                        hit_addr ? {24'h000000, addr_reg} :
                        hit_mask ? {24'h000000, mask_reg} :
                        hit_aux  ? {29'h00000000, aux_reg} : 32'h00000000;

   // ---------------- receiver ----------------
   uamar_pkg::uamar_rx_state_type rx_st_reg;
   logic [3:0] rx_ovs_reg;
   logic [3:0] rx_cnt_reg;
   logic [8:0] rx_sh_reg;
   logic       rxd_d_reg;
   logic       rx_done_ev;
   logic       rx9_val;
   logic       rx_load;
   logic       fe_ev;

   wire        rx_en   = ctl_reg[uamar_pkg::CTL_RXEN];
   wire        fall    = rxd_d_reg & ~rxd_i;
   wire        mid     = sample_tick_i & (rx_ovs_reg == uamar_pkg::OVS_MID);
   wire [3:0]  rx_bits = nine ? uamar_pkg::BITS_9 : uamar_pkg::BITS_8;
   wire [7:0]  rx_byte = nine ? rx_sh_reg[7:0] : rx_sh_reg[8:1];
   wire        rx_ninth = rx_sh_reg[8];
   // match on data bits once marker is in, before flags move
   wire [7:0]  bcast   = addr_reg | mask_reg;
   wire        given_m = ((rx_byte ^ addr_reg) & mask_reg) == 8'h00;
   wire        bcast_m = ((rx_byte ^ bcast) & bcast) == 8'h00;
   wire        match   = given_m | bcast_m;
   wire        stop_ok = rxd_i;

   // decide acceptance at mid stop bit
   always_comb begin
      rx_done_ev = 1'b0;
      rx_load    = 1'b0;
      rx9_val    = ctl_reg[uamar_pkg::CTL_RX9];
      fe_ev      = 1'b0;
      if (rx_st_reg == uamar_pkg::RX_STOP && mid) begin
         fe_ev = fcsel & ~stop_ok;
         if (nine) begin
            if (!mpen || (rx_ninth && match)) begin
               rx_done_ev = 1'b1;
               rx_load    = 1'b1;
               rx9_val    = rx_ninth;
            end
         end else begin
            if (!mpen || (stop_ok && match)) begin
               rx_done_ev = 1'b1;
               rx_load    = 1'b1;
               rx9_val    = stop_ok;
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rx_st_reg  <= uamar_pkg::RX_IDLE;
         rx_ovs_reg <= 4'h0;
         rx_cnt_reg <= 4'h0;
         rx_sh_reg  <= 9'h000;
         rxd_d_reg  <= 1'b1;
      end else begin
         rxd_d_reg <= rxd_i;
         if (sample_tick_i) begin
            rx_ovs_reg <= rx_ovs_reg + 4'h1;
         end
         case (rx_st_reg)
            uamar_pkg::RX_IDLE: begin
               if (rx_en && fall && mode != uamar_pkg::MODE_SHIFT) begin
                  rx_st_reg  <= uamar_pkg::RX_START;
                  rx_ovs_reg <= 4'h0;
               end
            end
            uamar_pkg::RX_START: begin
               if (mid) begin
                  // false start when line is high again at mid bit
                  rx_st_reg  <= rxd_i ? uamar_pkg::RX_IDLE : uamar_pkg::RX_DATA;
                  rx_cnt_reg <= 4'h0;
               end
            end
            uamar_pkg::RX_DATA: begin
               if (mid) begin
                  rx_sh_reg  <= {rxd_i, rx_sh_reg[8:1]};
                  rx_cnt_reg <= rx_cnt_reg + 4'h1;
                  if (rx_cnt_reg == rx_bits - 4'h1) begin
                     rx_st_reg <= uamar_pkg::RX_STOP;
                  end
               end
            end
            uamar_pkg::RX_STOP: begin
               if (mid) begin
                  if (!nine) begin
                     rx_sh_reg <= {rxd_i, rx_sh_reg[8:1]};
                  end
                  rx_st_reg <= uamar_pkg::RX_IDLE;
               end
            end
            default: rx_st_reg <= uamar_pkg::RX_IDLE;
         endcase
      end
   end

   // ---------------- transmitter ----------------
   logic       tx_busy_reg;
   logic [3:0] tx_ovs_reg;
   logic [3:0] tx_cnt_reg;
   logic [10:0] tx_sh_reg;
   logic       txd_reg;
   logic       tx_done_ev;

   wire [3:0]  tx_total = nine ? 4'hB : 4'hA; // start + data + ninth? + stop
   wire        tx_bit_end = tx_busy_reg & sample_tick_i & (tx_ovs_reg == uamar_pkg::OVS_LAST);
   // tx done after last data bit, i.e. when the stop bit begins
   assign tx_done_ev = tx_bit_end & (tx_cnt_reg == tx_total - 4'h2);

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tx_busy_reg <= 1'b0;
         tx_ovs_reg  <= 4'h0;
         tx_cnt_reg  <= 4'h0;
         tx_sh_reg   <= 11'h7FF;
         txd_reg     <= 1'b1;
      end else if (wr_buf) begin
         // restart on a write while busy; software should wait for tx done
         tx_busy_reg <= 1'b1;
         tx_ovs_reg  <= 4'h0;
         tx_cnt_reg  <= 4'h0;
         tx_sh_reg   <= nine ? {1'b1, ctl_reg[uamar_pkg::CTL_TX9], pwdata_i[7:0], 1'b0}
                             : {2'b11, pwdata_i[7:0], 1'b0};
         txd_reg     <= 1'b1;
      end else if (tx_busy_reg) begin
         txd_reg <= tx_sh_reg[0];
         if (sample_tick_i) begin
            tx_ovs_reg <= tx_ovs_reg + 4'h1;
         end
         if (tx_bit_end) begin
            tx_sh_reg  <= {1'b1, tx_sh_reg[10:1]};
            tx_cnt_reg <= tx_cnt_reg + 4'h1;
            if (tx_cnt_reg == tx_total - 4'h1) begin
               tx_busy_reg <= 1'b0;
            end
         end
      end else begin
         txd_reg <= 1'b1;
      end
   end

   // ---------------- registers ----------------
   wire [7:0] wd = pwdata_i[7:0];
   // set wins over a software clear in the same cycle
   wire rx_done_next = rx_done_ev | (wr_ctl ? wd[uamar_pkg::CTL_RXDONE]
                                            : ctl_reg[uamar_pkg::CTL_RXDONE]);
   wire tx_done_next = tx_done_ev | (wr_ctl ? wd[uamar_pkg::CTL_TXDONE]
                                            : ctl_reg[uamar_pkg::CTL_TXDONE]);
   wire rx9_next     = rx_load ? rx9_val : (wr_ctl ? wd[uamar_pkg::CTL_RX9]
                                                   : ctl_reg[uamar_pkg::CTL_RX9]);
   wire [3:0] hi_next = wr_ctl ? wd[6:3] : ctl_reg[6:3];
   wire fe_next   = fe_ev | ((wr_ctl && fcsel) ? wd[7] : fe_reg);
   wire m0_next   = (wr_ctl && !fcsel) ? wd[7] : mode0_reg;
   wire irq_src   = ctl_reg[uamar_pkg::CTL_RXDONE] | ctl_reg[uamar_pkg::CTL_TXDONE];
   wire irq_next  = irq_src & aux_reg[uamar_pkg::AUX_SIE] & aux_reg[uamar_pkg::AUX_GIE];

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctl_reg   <= uamar_pkg::CONTROL_RESET;
         mode0_reg <= 1'b0;
         fe_reg    <= 1'b0;
         buf_reg   <= 8'h00;
         addr_reg  <= uamar_pkg::ADDR_RESET;
         mask_reg  <= uamar_pkg::ADDR_RESET;
         aux_reg   <= uamar_pkg::AUX_RESET;
      end else begin
         ctl_reg   <= {1'b0, hi_next, rx9_next, tx_done_next, rx_done_next};
         mode0_reg <= m0_next;
         fe_reg    <= fe_next;
         if (rx_load) begin
            buf_reg <= rx_byte;
         end
         if (wr && hit_addr && pready_reg) begin
            addr_reg <= wd;
         end
         if (wr && hit_mask && pready_reg) begin
            mask_reg <= wd;
         end
         if (wr && hit_aux && pready_reg) begin
            aux_reg <= wd[2:0];
         end
      end
   end

   // apb answer: pready one cycle after access phase begins
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prdata_reg  <= 32'h00000000;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         irq_reg     <= 1'b0;
      end else begin
         pready_reg  <= acc & ~pready_reg;
         pslverr_reg <= acc & ~pready_reg & ~hit_any;
         prdata_reg  <= (acc && !pwrite_i && !pready_reg) ? rd_mux : 32'h00000000;
         irq_reg     <= irq_next;
      end
   end

   assign prdata_o     = prdata_reg;
   assign pready_o     = pready_reg;
   assign pslverr_o    = pslverr_reg;
   assign txd_o        = txd_reg;
   assign serial_irq_o = irq_reg;

endmodule : uamar_top
`default_nettype wire

/* bench/uamar_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module uamar_checker (
   // bus side
   input wire logic        clk_i,
   input wire logic        resetn_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [15:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   // serial side
   input wire logic        txd_o,
   input wire logic        serial_irq_o
);
   localparam logic [15:0] AUX = {2'b00, uamar_pkg::AUX_CONTROL_ADDR};
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   apb_answer_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
      else $error("access not answered after one wait state");
   ready_pulse_a: assert property (pready_o |=> !pready_o)
      else $error("ready held longer than one cycle");
   ready_cause_a: assert property (pready_o |-> $past(psel_i && penable_i))
      else $error("ready without an access");
   err_data_a: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0000_0000)
      else $error("error response not clean");
   // a write lands one edge before the gated request follows it
   irq_hold_a: assert property (serial_irq_o && !(psel_i && pwrite_i)
      && !$past(psel_i && pwrite_i) |=> serial_irq_o)
      else $error("interrupt dropped without a write");
   // aux read data and the request are both one cycle behind the same state
   irq_gate_a: assert property (pready_o && !pwrite_i && paddr_i == AUX
      && prdata_o[2:1] != 2'b11 |-> !serial_irq_o) else $error("interrupt passed while gated");
   reset_idle_a: assert property (disable iff (1'b0)
      !resetn_i |-> txd_o && !serial_irq_o && !pready_o) else $error("outputs not idle in reset");
   start_bit_a: assert property ($fell(txd_o) |=> !txd_o [*8])
      else $error("start bit too short");
   cover property (pslverr_o);
   cover property ($rose(serial_irq_o));
   cover property ($fell(txd_o));
endmodule : uamar_checker

bind uamar_top uamar_checker i_chk (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .txd_o(txd_o), .serial_irq_o(serial_irq_o));
`default_nettype wire

/* bench/uamar_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module uamar_peer (
   // timing
   input  wire logic clk_i,
   input  wire logic tick_i,
   // line toward the port
   output logic      rxd_o
);
   initial rxd_o = 1'b1;
   // nine selects the 11-bit frame; a zero stp gives a broken stop bit
   task automatic send(input logic [7:0] d, input logic nine, input logic m, input logic stp);
      logic [10:0] f;
      int          n;
      f = nine ? {stp, m, d, 1'b0} : {1'b1, stp, d, 1'b0};
      n = nine ? 11 : 10;
      @(posedge clk_i);
      for (int i = 0; i < n; i++) begin
         rxd_o <= f[i];
         repeat (16) @(posedge clk_i iff tick_i);
      end
      // idle gap so the next start edge is always a clean fall
      rxd_o <= 1'b1;
      repeat (16) @(posedge clk_i iff tick_i);
   endtask : send
endmodule : uamar_peer
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [15:0] A_CTL = {2'b00, uamar_pkg::SERIAL_CONTROL_ADDR};
   localparam logic [15:0] A_BUF = {2'b00, uamar_pkg::SERIAL_BUFFER_ADDR};
   localparam logic [15:0] A_VAL = {2'b00, uamar_pkg::NODE_ADDRESS_VALUE_ADDR};
   localparam logic [15:0] A_MSK = {2'b00, uamar_pkg::NODE_ADDRESS_MASK_ADDR};
   localparam logic [15:0] A_AUX = {2'b00, uamar_pkg::AUX_CONTROL_ADDR};
   logic        clk = 1'b0;
   logic        resetn = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic        tick = 1'b0;
   logic [31:0] prdata;
   logic        pready, pslverr, rxd, txd, irq;
   int          fail_count = 0;
   int          tests_run = 0;
   uamar_top i_dut (.clk_i(clk), .resetn_i(resetn), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .sample_tick_i(tick),
      .rxd_i(rxd), .txd_o(txd), .serial_irq_o(irq));
   uamar_peer i_peer (.clk_i(clk), .tick_i(tick), .rxd_o(rxd));
   initial begin
      forever #2.5 clk = ~clk;
   end
   // a tick every other cycle keeps frames short but not degenerate
   always @(posedge clk) tick <= ~tick;
   task finish_test;
      if (fail_count == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : finish_test
   task chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   // request held until the rising edge that samples pready high; data taken there
   task apb(input logic w, input logic [15:0] a, input logic [7:0] d,
            output logic [7:0] q, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata[7:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [15:0] a, input logic [7:0] d);
      logic [7:0] q;
      logic       e;
      apb(1'b1, a, d, q, e);
   endtask : wr
   task rchk(input logic [15:0] a, input logic [7:0] m, input logic [7:0] exp);
      logic [7:0] q;
      logic       e;
      apb(1'b0, a, 8'h00, q, e);
      chk(q & m, exp);
   endtask : rchk
   task t_reg;
      logic [7:0] q;
      logic       e;
      rchk(A_CTL, 8'hFF, 8'h00);
      rchk(A_VAL, 8'hFF, 8'h00);
      rchk(A_MSK, 8'hFF, 8'h00);
      apb(1'b0, 16'h0004, 8'h00, q, e);
      chk({q[6:0], e}, 8'h01);
      wr(A_CTL, 8'hB0);
      i_peer.send(8'h3C, 1'b1, 1'b1, 1'b1);
      rchk(A_CTL, 8'hFF, 8'hB5);
      wr(A_CTL, 8'hB0);
   endtask : t_reg
   task t_rx9;
      logic [7:0] ad [5];
      logic [4:0] mk;
      logic [4:0] ex;
      ad = '{8'h55, 8'hF0, 8'hF3, 8'hFF, 8'hFB};
      mk = 5'b11110;
      ex = 5'b11010;
      wr(A_VAL, 8'hF1);
      wr(A_MSK, 8'hFA);
      for (int i = 0; i < 5; i++) begin
         i_peer.send(ad[i], 1'b1, mk[i], 1'b1);
         rchk(A_CTL, 8'hFF, ex[i] ? 8'hB5 : 8'hB0);
         if (ex[i]) rchk(A_BUF, 8'hFF, ad[i]);
         wr(A_CTL, 8'hB0);
      end
      wr(A_CTL, 8'h90);
      i_peer.send(8'h5A, 1'b1, 1'b0, 1'b1);
      rchk(A_CTL, 8'hFF, 8'h91);
      rchk(A_BUF, 8'hFF, 8'h5A);
   endtask : t_rx9
   task t_rx8;
      wr(A_CTL, 8'h70);
      wr(A_VAL, 8'h56);
      wr(A_MSK, 8'hFF);
      for (int i = 0; i < 3; i++) begin
         i_peer.send(i == 1 ? 8'h57 : 8'h56, 1'b0, 1'b0, i != 2);
         rchk(A_CTL, 8'h01, i == 0 ? 8'h01 : 8'h00);
         wr(A_CTL, 8'h70);
      end
      wr(A_CTL, 8'h50);
      i_peer.send(8'h33, 1'b0, 1'b0, 1'b1);
      rchk(A_CTL, 8'hFF, 8'h55);
   endtask : t_rx8
   task t_fe;
      wr(A_CTL, 8'h50);
      wr(A_AUX, 8'h01);
      i_peer.send(8'h33, 1'b0, 1'b0, 1'b0);
      rchk(A_CTL, 8'h80, 8'h80);
      i_peer.send(8'h44, 1'b0, 1'b0, 1'b1);
      rchk(A_CTL, 8'h80, 8'h80);
      wr(A_CTL, 8'h50);
      rchk(A_CTL, 8'h80, 8'h00);
      wr(A_AUX, 8'h00);
   endtask : t_fe
   task t_tx;
      int n;
      wr(A_CTL, 8'h50);
      wr(A_AUX, 8'h06);
      wr(A_BUF, 8'hA5);
      n = 0;
      while (irq !== 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      chk({7'h00, irq}, 8'h01);
      rchk(A_CTL, 8'h03, 8'h02);
      wr(A_AUX, 8'h02);
      rchk(A_AUX, 8'h07, 8'h02);
      chk({7'h00, irq}, 8'h00);
   endtask : t_tx
   initial begin
      resetn <= 1'b0;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      t_reg;
      t_rx9;
      t_rx8;
      t_fe;
      t_tx;
      finish_test;
   end
   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      finish_test;
   end
endmodule : tb
`default_nettype wire
